/* File: rtl/ltd_core.sv */
// Decode and execute of test-under-mask, exclusive-OR and software vector call
`timescale 1ns/1ns
module ltd_core
	import ltd_pkg::*;
(
	input  logic          sys_clk_i,
	input  logic          rstn_i,
	input  logic          op_valid_i,
	input  logic [DW-1:0] op_byte_i,
	input  logic [DW-1:0] work_base_i,
	input  logic [DW-1:0] flags_i,
	input  logic [AW-1:0] stack_pointer_i,
	input  logic [AW-1:0] program_counter_i,
	input  logic [DW-1:0] mem_rdata_i,
	input  logic          ea_req_i,
	input  logic          ea_pair_i,
	input  logic [AW-1:0] ea_base_i,
	input  logic [DW-1:0] ea_disp_i,
	input  logic [3:0]    ea_sel_i,
	output logic          busy_o,
	output logic          mem_rd_o,
	output logic          mem_wr_o,
	output logic          mem_prog_o,
	output logic [AW-1:0] mem_addr_o,
	output logic [DW-1:0] mem_wdata_o,
	output logic [DW-1:0] flags_o,
	output logic          flags_we_o,
	output logic [AW-1:0] stack_pointer_o,
	output logic          stack_pointer_we_o,
	output logic [AW-1:0] program_counter_o,
	output logic          program_counter_load_o,
	output logic [AW-1:0] ea_addr_o,
	output logic          ea_done_o
);

	ltd_state_t         state;
	logic [DW-1:0]      opc;
	logic [1:0]         need;
	logic [1:0]         cnt;
	logic [DW-1:0]      ibuf [1:3];
	logic [AW-1:0]      src_a;
	logic [AW-1:0]      dst_a;
	logic               src_ind;
	logic               dst_ind;
	logic               src_imm;
	logic               ptr_src;
	logic [DW-1:0]      src_val;
	logic [AW-1:0]      stack_base;
	logic [AW-1:0]      saved_counter;
	logic               ea_pair_held;

	////////////////////////////////////////////////////////////////////////////
	// Operand decode
	wire logic [3:0]    lo        = opc[3:0];
	wire logic          is_trap   = (opc == OP_TRAP);
	wire logic          is_xor    = (opc[7:4] == HI_XOR);
	wire logic          is_mask   = (opc[7:4] == HI_MASK);
	wire logic [AW-1:0] ext_src   = {4'h0, ibuf[1], ibuf[2][7:4]};
	wire logic [AW-1:0] ext_dst   = {4'h0, ibuf[2][3:0], ibuf[3]};
	wire logic          d_src_ind = (lo == LO_R_IR) || (lo == LO_RG_IRG);
	wire logic          d_dst_ind = (lo == LO_IRG_IMM);
	wire logic          d_imm     = (lo == LO_RG_IMM) || (lo == LO_IRG_IMM) || (lo == LO_EXT_IMM);
	wire logic [DW-1:0] d_imm_val = (lo == LO_EXT_IMM) ? ibuf[1] : ibuf[2];
	wire logic [AW-1:0] d_dst     = (lo == LO_R_R || lo == LO_R_IR)       ? wreg(work_base_i, ibuf[1][7:4]) :
	                                (lo == LO_RG_RG || lo == LO_RG_IRG)   ? reg8(ibuf[2]) :
	                                (lo == LO_RG_IMM || lo == LO_IRG_IMM) ? reg8(ibuf[1]) : ext_dst;
	wire logic [AW-1:0] d_src     = (lo == LO_R_R || lo == LO_R_IR)       ? wreg(work_base_i, ibuf[1][3:0]) :
	                                (lo == LO_RG_RG || lo == LO_RG_IRG)   ? reg8(ibuf[1]) : ext_src;
	wire logic [AW-1:0] idx_addr  = ea_base_i + sext16(ea_disp_i);
	wire logic [AW-1:0] pair_addr = wreg(work_base_i, {ea_sel_i[3:1], 1'b0});
	wire logic [DW-1:0] alu_res;
	wire logic [DW-1:0] alu_flags;
	wire logic          trap_st   = (state == S_TR_PCL) || (state == S_TR_FL) || (state == S_TR_VH) ||
	                                (state == S_TR_VL) || (state == S_TR_DONE);

	ltd_alu u_alu (
		.a_i     (mem_rdata_i),
		.b_i     (src_val),
		.xor_i   (is_xor),
		.flags_i (flags_i),
		.res_o   (alu_res),
		.flags_o (alu_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= S_IDLE;
			opc <= BYTE_ZERO;
			need <= EXTRA_ONE;
			cnt <= CNT_FIRST;
			for (int i = 1; i <= 3; i++) begin
				ibuf[i] <= BYTE_ZERO;
			end
			src_a <= '0;
			dst_a <= '0;
			src_ind <= 1'b0;
			dst_ind <= 1'b0;
			src_imm <= 1'b0;
			ptr_src <= 1'b0;
			src_val <= BYTE_ZERO;
			stack_base <= '0;
			saved_counter <= '0;
			ea_pair_held <= 1'b0;
			busy_o <= 1'b0;
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_prog_o <= 1'b0;
			mem_addr_o <= '0;
			mem_wdata_o <= BYTE_ZERO;
			flags_o <= BYTE_ZERO;
			flags_we_o <= 1'b0;
			stack_pointer_o <= '0;
			stack_pointer_we_o <= 1'b0;
			program_counter_o <= '0;
			program_counter_load_o <= 1'b0;
			ea_addr_o <= '0;
			ea_done_o <= 1'b0;
		end else begin
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_prog_o <= 1'b0;
			flags_we_o <= 1'b0;
			stack_pointer_we_o <= 1'b0;
			program_counter_load_o <= 1'b0;
			ea_done_o <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (op_valid_i && op_known(op_byte_i)) begin
						opc <= op_byte_i;
						need <= op_extra(op_byte_i);
						cnt <= CNT_FIRST;
						busy_o <= 1'b1;
						state <= S_BYTES;
					end else if (ea_req_i) begin
						ea_pair_held <= ea_pair_i;
						if (ea_pair_i) begin
							mem_rd_o <= 1'b1;
							mem_addr_o <= pair_addr;
							busy_o <= 1'b1;
							state <= S_EA_HI;
						end else begin
							ea_addr_o <= idx_addr;
							ea_done_o <= 1'b1;
						end
					end
				end
				S_BYTES: begin
					if (op_valid_i) begin
						ibuf[cnt] <= op_byte_i;
						cnt <= cnt + CNT_STEP;
						if (cnt == need) begin
							state <= S_DECODE;
						end
					end
				end
				S_DECODE: begin
					if (is_trap) begin
						stack_base <= stack_pointer_i - STK_CTR_DEC;
						saved_counter <= program_counter_i;
						mem_wr_o <= 1'b1;
						mem_addr_o <= stack_pointer_i - STK_CTR_DEC;
						mem_wdata_o <= program_counter_i[AW-1:DW];
						state <= S_TR_PCL;
					end else begin
						src_a <= d_src;
						dst_a <= d_dst;
						src_ind <= d_src_ind;
						dst_ind <= d_dst_ind;
						src_imm <= d_imm;
						src_val <= d_imm_val;
						state <= S_RESOLVE;
					end
				end
				S_RESOLVE: begin
					mem_rd_o <= 1'b1;
					if (src_ind) begin
						mem_addr_o <= src_a;
						ptr_src <= 1'b1;
						state <= S_PTRW;
					end else if (dst_ind) begin
						mem_addr_o <= dst_a;
						ptr_src <= 1'b0;
						state <= S_PTRW;
					end else if (src_imm) begin
						mem_addr_o <= dst_a;
						state <= S_DSTW;
					end else begin
						mem_addr_o <= src_a;
						state <= S_SRCW;
					end
				end
				S_PTRW: begin
					if (ptr_src) begin
						src_a <= reg8(mem_rdata_i);
						src_ind <= 1'b0;
					end else begin
						dst_a <= reg8(mem_rdata_i);
						dst_ind <= 1'b0;
					end
					state <= S_RESOLVE;
				end
				S_SRCW: begin
					src_val <= mem_rdata_i;
					mem_rd_o <= 1'b1;
					mem_addr_o <= dst_a;
					state <= S_DSTW;
				end
				S_DSTW: begin
					flags_o <= alu_flags;
					flags_we_o <= 1'b1;
					if (is_xor) begin
						mem_wr_o <= 1'b1;
						mem_addr_o <= dst_a;
						mem_wdata_o <= alu_res;
					end
					busy_o <= 1'b0;
					state <= S_IDLE;
				end
				S_TR_PCL: begin
					mem_wr_o <= 1'b1;
					mem_addr_o <= stack_base + AD_ONE;
					mem_wdata_o <= saved_counter[DW-1:0];
					state <= S_TR_FL;
				end
				S_TR_FL: begin
					mem_wr_o <= 1'b1;
					mem_addr_o <= stack_base - STK_FL_DEC;
					mem_wdata_o <= flags_i;
					stack_pointer_o <= stack_base - STK_FL_DEC;
					stack_pointer_we_o <= 1'b1;
					state <= S_TR_VH;
				end
				S_TR_VH: begin
					mem_rd_o <= 1'b1;
					mem_prog_o <= 1'b1;
					mem_addr_o <= vec_addr(ibuf[1]);
					state <= S_TR_VL;
				end
				S_TR_VL: begin
					src_val <= mem_rdata_i;
					mem_rd_o <= 1'b1;
					mem_prog_o <= 1'b1;
					mem_addr_o <= vec_addr(ibuf[1]) + AD_ONE;
					state <= S_TR_DONE;
				end
				S_TR_DONE: begin
					program_counter_o <= {src_val, mem_rdata_i};
					program_counter_load_o <= 1'b1;
					busy_o <= 1'b0;
					state <= S_IDLE;
				end
				S_EA_HI: begin
					src_val <= mem_rdata_i;
					mem_rd_o <= 1'b1;
					mem_addr_o <= mem_addr_o + AD_ONE;
					state <= S_EA_LO;
				end
				S_EA_LO: begin
					ea_addr_o <= {src_val, mem_rdata_i};
					ea_done_o <= 1'b1;
					busy_o <= 1'b0;
					state <= S_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rstn_i);

	property p_mask_nowrite;
		flags_we_o && is_mask |-> !mem_wr_o;
	endproperty
	a_mask_nowrite: assert property (p_mask_nowrite) else $error("mask test wrote a result");

	property p_carry_kept;
		flags_we_o |-> flags_o[FL_C] == $past(flags_i[FL_C]) && !flags_o[FL_V];
	endproperty
	a_carry_kept: assert property (p_carry_kept) else $error("carry changed or overflow set");

	property p_trap_sp;
		stack_pointer_we_o |-> mem_wr_o && stack_pointer_o == mem_addr_o && $past(mem_addr_o, 2) == mem_addr_o + AD_ONE;
	endproperty
	a_trap_sp: assert property (p_trap_sp) else $error("trap stack layout wrong");

	property p_trap_noflag;
		trap_st |-> !flags_we_o;
	endproperty
	a_trap_noflag: assert property (p_trap_noflag) else $error("trap altered flags");

	property p_xor_write;
		flags_we_o && is_xor |-> mem_wr_o && mem_addr_o == dst_a && flags_o[FL_Z] == (mem_wdata_o == BYTE_ZERO);
	endproperty
	a_xor_write: assert property (p_xor_write) else $error("xor result or zero flag wrong");

	property p_ext_len;
		(state == S_BYTES) && op_valid_i && (lo == LO_EXT_EXT || lo == LO_EXT_IMM) && !is_trap && cnt == need
			|-> need == EXTRA_THREE;
	endproperty
	a_ext_len: assert property (p_ext_len) else $error("extended form not four bytes");

	property p_index;
		ea_done_o && !ea_pair_held |-> ea_addr_o == $past(ea_base_i) + sext16($past(ea_disp_i));
	endproperty
	a_index: assert property (p_index) else $error("indexed address not signed");

	property p_pair;
		ea_done_o && ea_pair_held |-> $past(mem_rd_o) && $past(mem_rd_o, 2) &&
			$past(mem_addr_o) == $past(mem_addr_o, 2) + AD_ONE;
	endproperty
	a_pair: assert property (p_pair) else $error("pair read not consecutive");

	property p_trap_order;
		program_counter_load_o |-> $past(stack_pointer_we_o, 3) && $past(mem_wr_o, 4) && $past(mem_wr_o, 5);
	endproperty
	a_trap_order: assert property (p_trap_order) else $error("counter loaded before stack writes");

	c_trap: cover property (program_counter_load_o);
	c_xor:  cover property (flags_we_o && is_xor);
	c_mask: cover property (flags_we_o && is_mask);
	c_pair: cover property (ea_done_o && ea_pair_held);

endmodule : ltd_core

/* File: rtl/ltd_pkg.sv */
// Constants, decode helpers and flag layout for the logic/test/trap decoder
package ltd_pkg;

	localparam int             DW          = 8;
	localparam int             AW          = 16;
	localparam logic [3:0]     HI_MASK     = 4'h7;
	localparam logic [3:0]     HI_XOR      = 4'hB;
	localparam logic [7:0]     OP_TRAP     = 8'hF2;
	localparam logic [3:0]     LO_R_R      = 4'h2;
	localparam logic [3:0]     LO_R_IR     = 4'h3;
	localparam logic [3:0]     LO_RG_RG    = 4'h4;
	localparam logic [3:0]     LO_RG_IRG   = 4'h5;
	localparam logic [3:0]     LO_RG_IMM   = 4'h6;
	localparam logic [3:0]     LO_IRG_IMM  = 4'h7;
	localparam logic [3:0]     LO_EXT_EXT  = 4'h8;
	localparam logic [3:0]     LO_EXT_IMM  = 4'h9;
	localparam logic [1:0]     EXTRA_ONE   = 2'h1;
	localparam logic [1:0]     EXTRA_TWO   = 2'h2;
	localparam logic [1:0]     EXTRA_THREE = 2'h3;
	localparam logic [1:0]     CNT_FIRST   = 2'h1;
	localparam logic [1:0]     CNT_STEP    = 2'h1;
	localparam logic [AW-1:0]  STK_CTR_DEC = 16'h0002;
	localparam logic [AW-1:0]  STK_FL_DEC  = 16'h0001;
	localparam logic [AW-1:0]  AD_ONE      = 16'h0001;
	localparam logic [DW-1:0]  BYTE_ZERO   = 8'h00;
	localparam int             FL_C        = 7;
	localparam int             FL_Z        = 6;
	localparam int             FL_S        = 5;
	localparam int             FL_V        = 4;

	typedef enum logic [3:0] {
		S_IDLE, S_BYTES, S_DECODE, S_RESOLVE, S_PTRW, S_SRCW, S_DSTW,
		S_TR_PCL, S_TR_FL, S_TR_VH, S_TR_VL, S_TR_DONE, S_EA_HI, S_EA_LO
	} ltd_state_t;

	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == OP_TRAP) ||
			(((op[7:4] == HI_MASK) || (op[7:4] == HI_XOR)) && (op[3:0] >= LO_R_R) && (op[3:0] <= LO_EXT_IMM));
	endfunction : op_known

	function automatic logic [1:0] op_extra(input logic [7:0] op);
		if (op == OP_TRAP || op[3:0] == LO_R_R || op[3:0] == LO_R_IR)
			op_extra = EXTRA_ONE;
		else if (op[3:0] == LO_EXT_EXT || op[3:0] == LO_EXT_IMM)
			op_extra = EXTRA_THREE;
		else
			op_extra = EXTRA_TWO;
	endfunction : op_extra

	function automatic logic [AW-1:0] reg8(input logic [7:0] r);
		reg8 = {BYTE_ZERO, r};
	endfunction : reg8

	function automatic logic [AW-1:0] wreg(input logic [7:0] base, input logic [3:0] n);
		wreg = {BYTE_ZERO, base[7:4], n};
	endfunction : wreg

	function automatic logic [AW-1:0] sext16(input logic [7:0] d);
		sext16 = {{8{d[7]}}, d};
	endfunction : sext16

	function automatic logic [AW-1:0] vec_addr(input logic [7:0] v);
		vec_addr = {7'h00, v, 1'b0};
	endfunction : vec_addr

endpackage : ltd_pkg

/* File: rtl/ltd_alu.sv */
// Logic unit: AND or XOR with zero, sign and overflow flag update
`timescale 1ns/1ns
module ltd_alu
	import ltd_pkg::*;
(
	input  logic [DW-1:0] a_i,
	input  logic [DW-1:0] b_i,
	input  logic          xor_i,
	input  logic [DW-1:0] flags_i,
	output logic [DW-1:0] res_o,
	output logic [DW-1:0] flags_o
);

	wire logic [DW-1:0] and_res;
	wire logic [DW-1:0] xor_res;

	assign and_res = a_i & b_i;
	assign xor_res = a_i ^ b_i;
	assign res_o   = xor_i ? xor_res : and_res;

	////////////////////////////////////////////////////////////////////////////
	// flags from result
	always_comb begin
		flags_o       = flags_i;
		flags_o[FL_Z] = (res_o == BYTE_ZERO);
		flags_o[FL_S] = res_o[DW-1];
		flags_o[FL_V] = 1'b0;
	end

endmodule : ltd_alu

/* File: testbench/ltd_mem_model.sv */
// Behavioural data and program memory on the far side of the decoder
`timescale 1ns/1ns
module ltd_mem_model
	import ltd_pkg::*;
(
	input  logic          clk_i,
	input  logic          rd_i,
	input  logic          wr_i,
	input  logic          prog_i,
	input  logic [AW-1:0] addr_i,
	input  logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem  [0:65535];
	logic [DW-1:0] prog [0:511];
	logic          tgl = 1'b0;
	////////////////////////////////////////////////////////////////////////////////
	// Read data valid only while a read is driven, churns otherwise
	assign rdata_o = !rd_i ? {4{tgl, ~tgl}} : prog_i ? prog[addr_i[8:0]] : mem[addr_i];
	always @(posedge clk_i) begin
		tgl <= ~tgl;
		if (wr_i)
			mem[addr_i] <= wdata_i;
	end
endmodule : ltd_mem_model

/* File: testbench/logic_test_trap_decode_tb.sv */
// Self-checking bench for the logic, test and trap decoder
`timescale 1ns/1ns
module logic_test_trap_decode_tb import ltd_pkg::*;;
	logic          sys_clk_i = 1'b0, rstn_i = 1'b0, op_valid_i = 1'b0, ea_req_i = 1'b0, ea_pair_i = 1'b0;
	logic [DW-1:0] op_byte_i = 8'h00, work_base_i = 8'h00, flags_i = 8'h00, ea_disp_i = 8'h00, mem_rdata_i;
	logic [AW-1:0] stack_pointer_i = 16'h0000, program_counter_i = 16'h0000, ea_base_i = 16'h0000;
	logic [3:0]    ea_sel_i = 4'h0;
	logic          busy_o, mem_rd_o, mem_wr_o, mem_prog_o, flags_we_o, stack_pointer_we_o;
	logic          program_counter_load_o, ea_done_o;
	logic [AW-1:0] mem_addr_o, stack_pointer_o, program_counter_o, ea_addr_o, stack_got, counter_got, ea_got;
	logic [DW-1:0] mem_wdata_o, flags_o;
	logic [23:0]   wq [$];
	logic [7:0]    fq [$];
	logic [7:0]    bs [0:3];
	int            err_total = 0, compares = 0, wr_at_load;

	ltd_core ltd_core_i (.sys_clk_i, .rstn_i, .op_valid_i, .op_byte_i, .work_base_i, .flags_i, .stack_pointer_i,
		.program_counter_i, .mem_rdata_i, .ea_req_i, .ea_pair_i, .ea_base_i, .ea_disp_i, .ea_sel_i, .busy_o,
		.mem_rd_o, .mem_wr_o, .mem_prog_o, .mem_addr_o, .mem_wdata_o, .flags_o, .flags_we_o, .stack_pointer_o,
		.stack_pointer_we_o, .program_counter_o, .program_counter_load_o, .ea_addr_o, .ea_done_o);
	ltd_mem_model ltd_mem_model_i (.clk_i(sys_clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .prog_i(mem_prog_o),
		.addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

	always #50 sys_clk_i = ~sys_clk_i;
	////////////////////////////////////////////////////////////////////////////////
	// Collects what the decoder hands out
	always @(negedge sys_clk_i) begin
		if (mem_wr_o === 1'b1)
			wq.push_back({mem_addr_o, mem_wdata_o});
		if (flags_we_o === 1'b1)
			fq.push_back(flags_o);
		if (stack_pointer_we_o === 1'b1)
			stack_got = stack_pointer_o;
		if (program_counter_load_o === 1'b1)
			wr_at_load = wq.size();
		if (program_counter_load_o === 1'b1)
			counter_got = program_counter_o;
		if (ea_done_o === 1'b1)
			ea_got = ea_addr_o;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] rd(input logic [15:0] a);
		rd = ltd_mem_model_i.mem[a];
	endfunction : rd
	task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_cnt(input int got, input int exp);
		chk_val(24'(got), 24'(exp));
	endtask : chk_cnt
	task automatic summarize();
		$display("Compares %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize
	task automatic send(input int n);
		wq.delete();
		fq.delete();
		stack_got = 'x;
		counter_got = 'x;
		wr_at_load = -1;
		for (int i = 0; i < n; i++) begin
			op_valid_i <= 1'b1;
			op_byte_i  <= bs[i];
			@(posedge sys_clk_i);
		end
		op_valid_i <= 1'b0;
	endtask : send
	task automatic wait_idle();
		int k;
		k = 0;
		do begin
			@(negedge sys_clk_i);
			k++;
		end while (busy_o !== 1'b0 && k < 40);
		chk_val({23'h0, busy_o}, 24'h0);
		@(negedge sys_clk_i);
		@(posedge sys_clk_i);
	endtask : wait_idle
	////////////////////////////////////////////////////////////////////////////////
	task automatic run_alu(input logic [7:0] op);
		logic [7:0]  wb, fl, s, r;
		logic [15:0] da, sa;
		wb = 8'($urandom);
		fl = 8'($urandom);
		bs = '{op, 8'($urandom), 8'($urandom), 8'($urandom)};
		sa = {8'h00, wb[7:4], bs[1][3:0]};
		da = {8'h00, wb[7:4], bs[1][7:4]};
		case (op[3:0])
			4'h3: sa = {8'h00, rd(sa)};
			4'h4: sa = {8'h00, bs[1]};
			4'h5: sa = {8'h00, rd({8'h00, bs[1]})};
			4'h8: sa = {4'h0, bs[1], bs[2][7:4]};
			default: ;
		endcase
		case (op[3:0])
			4'h4, 4'h5: da = {8'h00, bs[2]};
			4'h6: da = {8'h00, bs[1]};
			4'h7: da = {8'h00, rd({8'h00, bs[1]})};
			4'h8, 4'h9: da = {4'h0, bs[2][3:0], bs[3]};
			default: ;
		endcase
		s = (op[3:0] == 4'h6 || op[3:0] == 4'h7) ? bs[2] : (op[3:0] == 4'h9) ? bs[1] : rd(sa);
		r = (op[7:4] == HI_XOR) ? rd(da) ^ s : rd(da) & s;
		work_base_i <= wb;
		flags_i     <= fl;
		send((op[3:0] < 4'h4) ? 2 : (op[3:0] < 4'h8) ? 3 : 4);
		wait_idle();
		chk_cnt(fq.size(), 1);
		chk_val({16'h0, fq[0]}, {16'h0, fl[7], r == 8'h00, r[7], 1'b0, fl[3:0]});
		chk_cnt(wq.size(), (op[7:4] == HI_XOR) ? 1 : 0);
		if (op[7:4] == HI_XOR)
			chk_val(wq[0], {da, r});
	endtask : run_alu
	task automatic run_trap();
		logic [15:0] stk, ctr;
		logic [7:0]  fl, v;
		stk = 16'($urandom);
		ctr = 16'($urandom);
		fl  = 8'($urandom);
		v   = 8'($urandom);
		bs[0] = OP_TRAP;
		bs[1] = v;
		stack_pointer_i   <= stk;
		program_counter_i <= ctr;
		flags_i           <= fl;
		send(2);
		wait_idle();
		chk_cnt(wq.size(), 3);
		chk_val(wq[0], {stk - 16'h0002, ctr[15:8]});
		chk_val(wq[1], {stk - 16'h0001, ctr[7:0]});
		chk_val(wq[2], {stk - 16'h0003, fl});
		chk_val({8'h00, stack_got}, {8'h00, stk - 16'h0003});
		chk_val({8'h00, counter_got}, {8'h00, ltd_mem_model_i.prog[{v, 1'b0}], ltd_mem_model_i.prog[{v, 1'b1}]});
		chk_cnt(wr_at_load, 3);
		chk_cnt(fq.size(), 0);
	endtask : run_trap
	task automatic run_ea(input logic pair);
		logic [15:0] base, pa, exp;
		logic [7:0]  wb, d;
		logic [3:0]  sel;
		base = 16'($urandom);
		d    = 8'($urandom);
		wb   = 8'($urandom);
		sel  = 4'($urandom);
		pa   = {8'h00, wb[7:4], sel[3:1], 1'b0};
		exp  = pair ? {rd(pa), rd(pa + 16'h0001)} : base + {{8{d[7]}}, d};
		ea_got = 'x;
		work_base_i <= wb;
		ea_base_i   <= base;
		ea_disp_i   <= d;
		ea_sel_i    <= sel;
		ea_pair_i   <= pair;
		ea_req_i    <= 1'b1;
		@(posedge sys_clk_i);
		ea_req_i <= 1'b0;
		repeat (4) @(negedge sys_clk_i);
		@(posedge sys_clk_i);
		chk_val(ea_got, exp);
	endtask : run_ea
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(64));
		for (int a = 0; a < 4096; a++)
			ltd_mem_model_i.mem[a] = 8'($urandom);
		for (int a = 0; a < 512; a++)
			ltd_mem_model_i.prog[a] = 8'($urandom);
		repeat (2) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		@(posedge sys_clk_i);
		repeat (6)
			for (int k = 0; k < 16; k++)
				run_alu({(k < 8) ? HI_MASK : HI_XOR, 4'(k % 8 + 2)});
		repeat (4)
			run_trap();
		repeat (4) begin
			run_ea(1'b0);
			run_ea(1'b1);
		end
		foreach (bs[i]) begin
			bs[0] = (i == 0) ? 8'h5F : (i == 1) ? 8'h7A : (i == 2) ? 8'hB1 : 8'hF3;
			send(1);
			@(negedge sys_clk_i);
			chk_val({23'h0, busy_o}, 24'h0);
			@(posedge sys_clk_i);
		end
		summarize();
	end
	initial begin
		#1_000_000;
		err_total++;
		summarize();
	end
endmodule : logic_test_trap_decode_tb
